// >>> vlfd_pkg.sv
// Constants, field layouts and types for the line fault diagnosis block.
// Assumes a 25 MHz system clock and one-cycle sample and timeslot strobes.
package vlfd_pkg;

  // ----------------------------------------------------------------
  // Register map (index times four gives the APB byte address)
  // ----------------------------------------------------------------
  localparam int unsigned IDX_DIAG_CTRL = 2;
  localparam int unsigned IDX_COMMAND = 3;
  localparam int unsigned IDX_STATUS = 4;
  localparam int unsigned IDX_CODING = 5;
  localparam logic [7:0] ADDR_DIAG_CTRL = 8'(4 * IDX_DIAG_CTRL);
  localparam logic [7:0] ADDR_COMMAND = 8'(4 * IDX_COMMAND);
  localparam logic [7:0] ADDR_STATUS = 8'(4 * IDX_STATUS);
  localparam logic [7:0] ADDR_CODING = 8'(4 * IDX_CODING);

  // Field positions and reset values
  localparam int unsigned CMD_MANUAL_TICK_BIT = 0;
  localparam int unsigned CODING_PULSED_BIT = 0;
  localparam logic [7:0] DIAG_CTRL_RST = 8'h00;
  localparam logic CODING_PULSED_RST = 1'h0;
  localparam logic [2:0] LINE_IDLE_RST = 3'h7;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [2:0] FILT_SAMPLES = 3'h5;
  localparam logic [2:0] EDGE_LIMIT = 3'h4;
  localparam logic [3:0] DOM_SLOTS = 4'h8;
  localparam logic [3:0] TX_GUARD_SAMPLES = 4'h7;
  localparam logic [1:0] RECOVER_TICKS = 2'h2;
  localparam int unsigned TICK_CNT_W = 22;
  localparam logic [TICK_CNT_W-1:0] TICK_BASE_DIV = 22'h000040;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VLFD_NOMINAL = 2'b00,
    VLFD_ON_B = 2'b01,
    VLFD_ON_A = 2'b10,
    VLFD_MAJOR = 2'b11
  } vlfd_state_type;

  typedef enum logic [1:0] {
    VLFD_FORCE_DIFF = 2'b00,
    VLFD_FORCE_B = 2'b01,
    VLFD_FORCE_A = 2'b10,
    VLFD_AUTO = 2'b11
  } vlfd_mode_type;

  typedef struct packed {
    logic [3:0] tick_div_sel;
    vlfd_mode_type mode;
    logic tx_diag_enable;
    logic diag_tick_div_enable;
  } vlfd_diag_ctrl_type;

  typedef struct packed {
    logic sof_start;
    logic id_start;
    logic rtr_start;
    logic ack_only;
    logic eof_done;
    logic arb_lost;
    logic code_viol;
  } vlfd_tx_event_type;

endpackage : vlfd_pkg

// >>> vlfd_line_diag.sv
// Line fault diagnosis: input filtering, fault analyses, source selection, APB registers.
// Assumes frame logic supplies sample/timeslot strobes, end-of-frame and transmit events.
`timescale 1ns/1ps
`default_nettype none

module vlfd_line_diag
(
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Line receivers
  input wire logic diff_line_input_in,
  input wire logic single_line_input_a_in,
  input wire logic single_line_input_b_in,
  // Frame logic strobes
  input wire logic sample_tick_in,
  input wire logic timeslot_tick_in,
  input wire logic line_transmit_in,
  input wire logic eof_detect_in,
  input wire vlfd_pkg::vlfd_tx_event_type tx_event_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Diagnosis results
  output logic rx_data_out,
  output logic line_state_hi_out,
  output logic line_state_lo_out,
  output logic input_mismatch_flag_out,
  output logic return_idle_pulse_out,
  output logic sync_diag_tick_out,
  output logic tx_active_window_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vlfd_pkg::vlfd_diag_ctrl_type ctrl_q;
  vlfd_pkg::vlfd_state_type state_q;
  vlfd_pkg::vlfd_state_type state_d;
  logic pulsed_q;
  logic manual_tick_q;
  logic div_tick_q;
  logic [vlfd_pkg::TICK_CNT_W-2:0] div_cnt_q;
  logic [vlfd_pkg::TICK_CNT_W-1:0] div_full;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] lvl_q;
  logic [2:0] filt_q;
  logic [2:0] edge_q;
  logic [2:0] fcnt_q [3];
  logic [2:0] cnt_a_q;
  logic [2:0] cnt_b_q;
  logic [2:0] sync_cnt_q;
  logic [3:0] dom_cnt_q;
  logic [3:0] txdom_cnt_q;
  logic [1:0] quiet_q;
  logic fail_seen_q;
  logic alt_q;
  logic tip_q;
  logic mis_flag_q;
  logic pready_q;
  logic [31:0] rd_data;
  logic hit;
  logic access;
  logic [1:0] sel;
  logic auto_mode;
  logic ri_now;
  logic tick_now;
  logic mismatch;
  logic fail_a;
  logic fail_b;
  logic major;
  logic fail_any;
  logic recover;

  assign access = psel_in & penable_in;
  assign auto_mode = (ctrl_q.mode == vlfd_pkg::VLFD_AUTO);
  assign ri_now = eof_detect_in & ~auto_mode;
  assign tick_now = div_tick_q | manual_tick_q;
  assign mismatch = ~((filt_q[0] == filt_q[1]) && (filt_q[1] == filt_q[2]));
  assign fail_any = fail_a | fail_b | major;

  // ----------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h0;
    hit = 1'h1;
    case (paddr_in)
      vlfd_pkg::ADDR_DIAG_CTRL: rd_data = {24'h0, ctrl_q};
      vlfd_pkg::ADDR_COMMAND: rd_data = 32'h0;
      vlfd_pkg::ADDR_STATUS: rd_data = {29'h0, state_q, mis_flag_q};
      vlfd_pkg::ADDR_CODING: rd_data = {31'h0, pulsed_q};
      default: hit = 1'h0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pready_q <= 1'h0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'h0;
      ctrl_q <= vlfd_pkg::DIAG_CTRL_RST;
      pulsed_q <= vlfd_pkg::CODING_PULSED_RST;
      manual_tick_q <= 1'h0;
    end
    else if (ce_in)
    begin
      pready_q <= access & ~pready_q;
      manual_tick_q <= 1'h0;
      if (access && !pready_q)
      begin
        prdata_out <= pwrite_in ? 32'h0 : rd_data;
        pslverr_out <= ~hit;
      end
      if (access && pready_q && pwrite_in)
      begin
        case (paddr_in)
          vlfd_pkg::ADDR_DIAG_CTRL: ctrl_q <= vlfd_pkg::vlfd_diag_ctrl_type'(pwdata_in[7:0]);
          vlfd_pkg::ADDR_COMMAND: manual_tick_q <= pwdata_in[vlfd_pkg::CMD_MANUAL_TICK_BIT];
          vlfd_pkg::ADDR_CODING: pulsed_q <= pwdata_in[vlfd_pkg::CODING_PULSED_BIT];
          default: ;
        endcase
      end
    end
  end

  assign pready_out = pready_q;

  // ----------------------------------------------------------------
  // Input synchronisers and digital filters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_q <= vlfd_pkg::LINE_IDLE_RST;
      s2_q <= vlfd_pkg::LINE_IDLE_RST;
      s3_q <= vlfd_pkg::LINE_IDLE_RST;
      lvl_q <= vlfd_pkg::LINE_IDLE_RST;
      filt_q <= vlfd_pkg::LINE_IDLE_RST;
      edge_q <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        fcnt_q[i] <= 3'h0;
      end
    end
    else if (ce_in)
    begin
      s1_q <= {single_line_input_b_in, single_line_input_a_in, diff_line_input_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      edge_q <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          lvl_q[i] <= s3_q[i];
        end
        if (sample_tick_in)
        begin
          if (lvl_q[i] == filt_q[i])
          begin
            fcnt_q[i] <= 3'h0;
          end
          else if (fcnt_q[i] == vlfd_pkg::FILT_SAMPLES - 3'h1)
          begin
            filt_q[i] <= lvl_q[i];
            fcnt_q[i] <= 3'h0;
            edge_q[i] <= 1'h1;
          end
          else
          begin
            fcnt_q[i] <= fcnt_q[i] + 3'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  always_comb
  begin
    case (ctrl_q.mode)
      vlfd_pkg::VLFD_FORCE_DIFF: sel = 2'h0;
      vlfd_pkg::VLFD_FORCE_B: sel = 2'h2;
      vlfd_pkg::VLFD_FORCE_A: sel = 2'h1;
      default:
      begin
        case (state_q)
          vlfd_pkg::VLFD_ON_B: sel = 2'h2;
          vlfd_pkg::VLFD_ON_A: sel = 2'h1;
          vlfd_pkg::VLFD_MAJOR: sel = alt_q ? 2'h2 : 2'h1;
          default: sel = 2'h0;
        endcase
      end
    endcase
    if (pulsed_q)
    begin
      sel = 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Diagnosis tick divider
  // ----------------------------------------------------------------
  assign div_full = vlfd_pkg::TICK_BASE_DIV << ctrl_q.tick_div_sel;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_cnt_q <= '0;
      div_tick_q <= 1'h0;
    end
    else if (ce_in)
    begin
      div_tick_q <= 1'h0;
      if (!ctrl_q.diag_tick_div_enable)
      begin
        div_cnt_q <= '0;
      end
      else if (timeslot_tick_in)
      begin
        if (div_cnt_q == div_full[vlfd_pkg::TICK_CNT_W-2:0] - 1'h1)
        begin
          div_cnt_q <= '0;
          div_tick_q <= 1'h1;
        end
        else
        begin
          div_cnt_q <= div_cnt_q + 1'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transition and protocol analyses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_a_q <= 3'h0;
      cnt_b_q <= 3'h0;
      sync_cnt_q <= 3'h0;
      dom_cnt_q <= 4'h0;
      txdom_cnt_q <= 4'h0;
    end
    else if (ce_in)
    begin
      if (eof_detect_in || tick_now)
      begin
        cnt_a_q <= 3'h0;
        cnt_b_q <= 3'h0;
      end
      else
      begin
        if (edge_q[1] && cnt_a_q != vlfd_pkg::EDGE_LIMIT)
        begin
          cnt_a_q <= cnt_a_q + 3'h1;
        end
        if (edge_q[2] && cnt_b_q != vlfd_pkg::EDGE_LIMIT)
        begin
          cnt_b_q <= cnt_b_q + 3'h1;
        end
      end
      if (tick_now)
      begin
        sync_cnt_q <= 3'h0;
      end
      else if (edge_q[sel] && sync_cnt_q != vlfd_pkg::EDGE_LIMIT)
      begin
        sync_cnt_q <= sync_cnt_q + 3'h1;
      end
      if (timeslot_tick_in)
      begin
        if (filt_q[sel])
        begin
          dom_cnt_q <= 4'h0;
        end
        else if (dom_cnt_q != vlfd_pkg::DOM_SLOTS)
        begin
          dom_cnt_q <= dom_cnt_q + 4'h1;
        end
      end
      if (!tip_q || line_transmit_in)
      begin
        txdom_cnt_q <= 4'h0;
      end
      else if (sample_tick_in && txdom_cnt_q != vlfd_pkg::TX_GUARD_SAMPLES)
      begin
        txdom_cnt_q <= txdom_cnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Diagnosis state
  // ----------------------------------------------------------------
  always_comb
  begin
    fail_a = 1'h0;
    fail_b = 1'h0;
    major = 1'h0;
    if (!pulsed_q)
    begin
      // Period closing: counts about to clear must not block a recovery
      fail_b = (cnt_a_q == vlfd_pkg::EDGE_LIMIT) && (cnt_b_q == 3'h0) && !eof_detect_in && !tick_now;
      fail_a = (cnt_b_q == vlfd_pkg::EDGE_LIMIT) && (cnt_a_q == 3'h0) && !eof_detect_in && !tick_now;
      if (txdom_cnt_q == vlfd_pkg::TX_GUARD_SAMPLES && filt_q[1] != filt_q[2])
      begin
        fail_b = fail_b | ~filt_q[1];
        fail_a = fail_a | ~filt_q[2];
      end
      major = (tick_now && sync_cnt_q < vlfd_pkg::EDGE_LIMIT)
        || (dom_cnt_q == vlfd_pkg::DOM_SLOTS);
    end
    if (auto_mode)
    begin
      recover = tick_now && !fail_seen_q && !fail_any
        && (quiet_q == vlfd_pkg::RECOVER_TICKS - 2'h1);
    end
    else
    begin
      recover = ri_now;
    end
    state_d = recover ? vlfd_pkg::VLFD_NOMINAL : state_q;
    state_d = vlfd_pkg::vlfd_state_type'(state_d | {fail_b, fail_a});
    if (major)
    begin
      state_d = vlfd_pkg::VLFD_MAJOR;
    end
    if (pulsed_q)
    begin
      state_d = vlfd_pkg::VLFD_NOMINAL;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= vlfd_pkg::VLFD_NOMINAL;
      quiet_q <= 2'h0;
      fail_seen_q <= 1'h0;
      alt_q <= 1'h0;
    end
    else if (ce_in)
    begin
      state_q <= state_d;
      if (tick_now)
      begin
        fail_seen_q <= 1'h0;
        quiet_q <= (fail_seen_q || fail_any || recover) ? 2'h0 : quiet_q + 2'h1;
        alt_q <= (state_q == vlfd_pkg::VLFD_MAJOR) ? ~alt_q : alt_q;
      end
      else if (fail_any)
      begin
        fail_seen_q <= 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mismatch flag, transmit window and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mis_flag_q <= 1'h0;
    end
    else if (ce_in)
    begin
      if (mismatch && !pulsed_q)
      begin
        mis_flag_q <= 1'h1;
      end
      else if (ri_now)
      begin
        mis_flag_q <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tip_q <= 1'h0;
    end
    else if (ce_in)
    begin
      if (!ctrl_q.tx_diag_enable)
      begin
        tip_q <= 1'h0;
      end
      else if (tx_event_in.eof_done || tx_event_in.arb_lost || tx_event_in.code_viol)
      begin
        tip_q <= 1'h0;
      end
      else if (!tx_event_in.ack_only
        && (tx_event_in.sof_start || tx_event_in.id_start || tx_event_in.rtr_start))
      begin
        tip_q <= 1'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_data_out <= 1'h1;
      line_state_hi_out <= 1'h0;
      line_state_lo_out <= 1'h0;
      input_mismatch_flag_out <= 1'h0;
      return_idle_pulse_out <= 1'h0;
      sync_diag_tick_out <= 1'h0;
      tx_active_window_out <= 1'h0;
    end
    else if (ce_in)
    begin
      rx_data_out <= filt_q[sel];
      {line_state_hi_out, line_state_lo_out} <= state_q;
      input_mismatch_flag_out <= mis_flag_q;
      return_idle_pulse_out <= ri_now;
      sync_diag_tick_out <= tick_now;
      tx_active_window_out <= tip_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_state_report;
    ce_in |=> ({line_state_hi_out, line_state_lo_out} == $past(state_q));
  endproperty
  a_state_report: assert property (p_state_report) else $error("state bits not reported");

  property p_flag_set;
    ce_in && mismatch && !pulsed_q |=> mis_flag_q ##1 (input_mismatch_flag_out || !$past(ce_in));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("mismatch flag not set");

  property p_flag_clear;
    $fell(mis_flag_q) |-> $past(ri_now) && $past(ce_in);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("mismatch flag cleared without idle pulse");

  property p_auto_no_ri;
    ce_in && auto_mode |=> !return_idle_pulse_out;
  endproperty
  a_auto_no_ri: assert property (p_auto_no_ri) else $error("idle pulse in automatic mode");

  property p_protocol_major;
    ce_in && !pulsed_q && dom_cnt_q == 4'h8 |=> state_q == vlfd_pkg::VLFD_MAJOR;
  endproperty
  a_protocol_major: assert property (p_protocol_major) else $error("no major after dominant run");

  property p_sync_major;
    ce_in && !pulsed_q && tick_now && sync_cnt_q < 3'h4 |=> state_q == vlfd_pkg::VLFD_MAJOR;
  endproperty
  a_sync_major: assert property (p_sync_major) else $error("no major after quiet tick period");

  property p_ri_nominal;
    ce_in && ri_now && !fail_any |=> state_q == vlfd_pkg::VLFD_NOMINAL;
  endproperty
  a_ri_nominal: assert property (p_ri_nominal) else $error("idle pulse did not restore nominal");

  property p_pulsed_off;
    ce_in && pulsed_q |-> (sel == 2'h0) ##1 (state_q == vlfd_pkg::VLFD_NOMINAL);
  endproperty
  a_pulsed_off: assert property (p_pulsed_off) else $error("diagnosis active in pulsed coding");

  property p_tip_disabled;
    ce_in && !ctrl_q.tx_diag_enable |=> !tip_q ##1 (!tx_active_window_out || !$past(ce_in));
  endproperty
  a_tip_disabled: assert property (p_tip_disabled) else $error("window while generation disabled");

  property p_filter_five;
    ce_in && edge_q[0] |-> $past(sample_tick_in) && $past(fcnt_q[0]) == 3'h4;
  endproperty
  a_filter_five: assert property (p_filter_five) else $error("filter accepted short level");

  c_degraded: cover property (state_q == vlfd_pkg::VLFD_NOMINAL ##1 state_q == vlfd_pkg::VLFD_ON_A);
  c_major_alt: cover property (state_q == vlfd_pkg::VLFD_MAJOR && tick_now ##1 alt_q);
  c_auto_recover: cover property (auto_mode && recover && state_q != vlfd_pkg::VLFD_NOMINAL);
  c_tx_fault: cover property (txdom_cnt_q == 4'h7 && filt_q[1] != filt_q[2]);

endmodule : vlfd_line_diag

`default_nettype wire

// >>> vlfd_line_rx_model.sv
// Behavioural model of the three line receivers on the two-wire bus.
// Assumes the bench drives the bus level and a stuck-recessive fault per conductor.
`timescale 1ns/1ps
`default_nettype none

module vlfd_line_rx_model
(
  // Bus level and faults
  input wire logic bus_level_in,
  input wire logic stuck_a_in,
  input wire logic stuck_b_in,
  // Receiver outputs
  output logic diff_out,
  output logic single_a_out,
  output logic single_b_out
);
  // A broken conductor reads recessive whatever the bus does
  assign diff_out = bus_level_in | (stuck_a_in & stuck_b_in);
  assign single_a_out = bus_level_in | stuck_a_in;
  assign single_b_out = bus_level_in | stuck_b_in;
endmodule : vlfd_line_rx_model

`default_nettype wire

// >>> van_line_fault_diagnosis_bench.sv
// Self-checking bench for the line fault diagnosis block.
// Assumes the design and receiver model files are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module van_line_fault_diagnosis_bench;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, bus = 1, stk_a = 0, stk_b = 0;
  logic ts = 0, eof = 0, ltx = 1, rd0, rd1, rd2, pready, pslverr, rx, s_hi, s_lo, flag, ri, tick, tx_active_window;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [32:0] exp_q[$], exp_w;
  vlfd_pkg::vlfd_tx_event_type txe = '0;
  int error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'h7258, k;

  initial forever #20 clk = ~clk;

  vlfd_line_rx_model i_rx (.bus_level_in(bus), .stuck_a_in(stk_a), .stuck_b_in(stk_b),
    .diff_out(rd0), .single_a_out(rd1), .single_b_out(rd2));

  vlfd_line_diag i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .diff_line_input_in(rd0),
    .single_line_input_a_in(rd1), .single_line_input_b_in(rd2), .sample_tick_in(1'b1),
    .timeslot_tick_in(ts), .line_transmit_in(ltx), .eof_detect_in(eof), .tx_event_in(txe),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rx_data_out(rx),
    .line_state_hi_out(s_hi), .line_state_lo_out(s_lo), .input_mismatch_flag_out(flag),
    .return_idle_pulse_out(ri), .sync_diag_tick_out(tick), .tx_active_window_out(tx_active_window));

  // ----------------------------------------------------------------
  // Bus tasks and result watcher
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask : rd

  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      exp_w = exp_q.pop_front();
      `CHK({pslverr, prdata}, exp_w)
    end
  end

  task automatic pulse_eof(input logic e);
    int seen;
    seen = 0;
    @(posedge clk) eof <= 1;
    @(posedge clk) eof <= 0;
    repeat (4)
    begin
      @(posedge clk);
      if (ri === 1'b1) seen++;
    end
    `CHK(seen, e)
  endtask : pulse_eof

  task automatic tx_pulse(input logic [6:0] ev, input logic e);
    @(posedge clk) txe <= vlfd_pkg::vlfd_tx_event_type'(ev);
    @(posedge clk) txe <= '0;
    repeat (3) @(posedge clk);
    `CHK(tx_active_window, e)
  endtask : tx_pulse

  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    r = $random(seed);
    rd(vlfd_pkg::ADDR_STATUS, 33'h0);
    apb(1, vlfd_pkg::ADDR_DIAG_CTRL, r);
    rd(vlfd_pkg::ADDR_DIAG_CTRL, {25'h0, r[7:0]});
    rd(8'h40, {1'b1, 32'h0});
    apb(1, vlfd_pkg::ADDR_DIAG_CTRL, 0);
    $display("test registers done");
    stk_a <= 1;
    bus <= 0;
    repeat (20) @(posedge clk);
    bus <= 1;
    stk_a <= 0;
    repeat (20) @(posedge clk);
    rd(vlfd_pkg::ADDR_STATUS, 33'h1);
    rd(vlfd_pkg::ADDR_STATUS, 33'h1);
    pulse_eof(1);
    rd(vlfd_pkg::ADDR_STATUS, 33'h0);
    $display("test mismatch done");
    stk_b <= 1;
    repeat (4)
    begin
      @(posedge clk) bus <= ~bus;
      repeat (12) @(posedge clk);
    end
    rd(vlfd_pkg::ADDR_STATUS, 33'h5);
    `CHK(rx, 1'b1)
    stk_b <= 0;
    pulse_eof(1);
    rd(vlfd_pkg::ADDR_STATUS, 33'h0);
    $display("test async done");
    bus <= 0;
    repeat (14)
    begin
      repeat (3) @(posedge clk);
      ts <= 1;
      @(posedge clk) ts <= 0;
    end
    rd(vlfd_pkg::ADDR_STATUS, 33'h6);
    bus <= 1;
    repeat (12) @(posedge clk);
    ts <= 1;
    @(posedge clk) ts <= 0;
    pulse_eof(1);
    rd(vlfd_pkg::ADDR_STATUS, 33'h0);
    $display("test protocol done");
    apb(1, vlfd_pkg::ADDR_DIAG_CTRL, 32'h2);
    for (k = 0; k < 3; k++)
    begin
      tx_pulse(7'h40 >> k, 1);
      tx_pulse(7'h04 >> k, 0);
    end
    tx_pulse(7'h28, 0);
    tx_pulse(7'h40, 1);
    stk_b <= 1;
    bus <= 0;
    ltx <= 0;
    repeat (20) @(posedge clk);
    rd(vlfd_pkg::ADDR_STATUS, 33'h5);
    ltx <= 1;
    bus <= 1;
    stk_b <= 0;
    repeat (12) @(posedge clk);
    tx_pulse(7'h04, 0);
    pulse_eof(1);
    rd(vlfd_pkg::ADDR_STATUS, 33'h0);
    apb(1, vlfd_pkg::ADDR_DIAG_CTRL, 32'h0);
    tx_pulse(7'h40, 0);
    $display("test window done");
    apb(1, vlfd_pkg::ADDR_CODING, 32'h1);
    rd(vlfd_pkg::ADDR_CODING, 33'h1);
    stk_b <= 1;
    repeat (4)
    begin
      @(posedge clk) bus <= ~bus;
      repeat (12) @(posedge clk);
    end
    rd(vlfd_pkg::ADDR_STATUS, 33'h0);
    pulse_eof(1);
    stk_b <= 0;
    apb(1, vlfd_pkg::ADDR_CODING, 32'h0);
    $display("test pulsed done");
    apb(1, vlfd_pkg::ADDR_DIAG_CTRL, 32'h0d);
    ts <= 1;
    repeat (3) @(posedge clk);
    k = 0;
    repeat (128)
    begin
      @(posedge clk);
      if (tick === 1'b1) k++;
    end
    `CHK(k, 2)
    repeat (80) @(posedge clk);
    rd(vlfd_pkg::ADDR_STATUS, 33'h6);
    pulse_eof(0);
    rd(vlfd_pkg::ADDR_STATUS, 33'h6);
    repeat (60)
    begin
      @(posedge clk) bus <= ~bus;
      repeat (6) @(posedge clk);
    end
    ts <= 0;
    rd(vlfd_pkg::ADDR_STATUS, 33'h0);
    $display("test auto done");
    apb(1, vlfd_pkg::ADDR_DIAG_CTRL, 32'h0c);
    pulse_eof(0);
    stk_b <= 1;
    repeat (4)
    begin
      @(posedge clk) bus <= ~bus;
      repeat (12) @(posedge clk);
    end
    bus <= 0;
    repeat (14) @(posedge clk);
    `CHK(rx, 1'b0)
    rd(vlfd_pkg::ADDR_STATUS, 33'h5);
    $display("test route done");
    complete_run;
  end
endmodule : van_line_fault_diagnosis_bench

`default_nettype wire
